// ===== dv/sar_core_model.sv
`timescale 1ns/10ps
module sar_core_model
  import sar_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // program memory
  input  wire logic [15:0] pm_addr,
  input  wire logic        pm_rd,
  output logic [15:0]      pm_rdata,
  // address stack
  output logic [2:0]       stack_index,
  input  wire logic [2:0]  stack_index_d,
  input  wire logic        stack_index_wr,
  input  wire sar_stack_req_s stack_req,
  output logic [15:0]      stack_rdata,
  // register file
  input  wire logic [6:0]  register_file_addr,
  input  wire logic        register_file_rd,
  input  wire logic        register_file_wr,
  input  wire logic [3:0]  register_file_wdata,
  output logic [3:0]       register_file_rdata
);
  logic [15:0] stk [8];
  logic [3:0]  rf [128];
  // word is scrambled address; idle bus shows other data
  assign pm_rdata = pm_rd ? ~pm_addr : pm_addr;
  assign stack_rdata = stk[stack_index];
  assign register_file_rdata = register_file_rd ? rf[register_file_addr] : ~rf[register_file_addr];
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stack_index <= 3'h0;
    end else begin
      if (stack_index_wr) stack_index <= stack_index_d;
      if (stack_req.wr) stk[stack_req.idx] <= stack_req.wdata;
      if (register_file_wr) rf[register_file_addr] <= register_file_wdata;
    end
  end
endmodule

// ===== dv/sar_sysregs_asserts.sv
`timescale 1ns/10ps
module sar_sysregs_asserts
  import sar_pkg::*;
#(
  parameter int PAP_W  = 16,
  parameter int SIDX_W = 3
) (
  // clock and resets
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              wdt_stack_fault_reset,
  input wire logic              chip_enable_reset,
  // watched ports
  input wire sar_op_e           op,
  input wire sar_dm_req_s       dm_req,
  input wire logic [3:0]        dm_rdata,
  input wire logic              dm_hit,
  input wire logic [3:0]        dm_bank,
  input wire logic [PAP_W-1:0]  pm_addr,
  input wire logic [15:0]       pm_rdata,
  input wire logic [15:0]       data_buffer_wdata,
  input wire logic [SIDX_W-1:0] stack_index,
  input wire logic [SIDX_W-1:0] stack_index_d,
  input wire sar_stack_req_s    stack_req,
  input wire logic [15:0]       stack_rdata,
  input wire sar_pc_req_s       pc_req
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  // sync resets win over pointer and bank loads
  wire run = !wdt_stack_fault_reset && !chip_enable_reset;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_step_plus_one: assert property (op == SAR_OP_STEP && run |=> pm_addr == $past(pm_addr) + 1'b1)
    else $error("pointer step wrong");
  a_sync_clears: assert property (!run |=> pm_addr == '0 && dm_bank == 4'h0)
    else $error("sync reset did not clear");
  a_table_word: assert property (op == SAR_OP_TABLE_RD |-> data_buffer_wdata == pm_rdata)
    else $error("table word not passed");
  a_save_entry: assert property (op == SAR_OP_SAVE |-> stack_req.wr && stack_req.idx == stack_index - 1'b1
    && stack_index_d == stack_index - 1'b1 && stack_req.wdata == pm_addr) else $error("save wrong");
  a_restore_entry: assert property (op == SAR_OP_RESTORE && run |-> stack_index_d == stack_index + 1'b1
    ##1 pm_addr == $past(stack_rdata)) else $error("restore wrong");
  a_jump_target: assert property (op inside {SAR_OP_IND_JUMP, SAR_OP_IND_CALL} |-> pc_req.target == pm_addr
    && pc_req.jump == (op == SAR_OP_IND_JUMP) && pc_req.call == (op == SAR_OP_IND_CALL)) else $error("pc wrong");
  a_bank_load: assert property (dm_req.wr && dm_req.addr == 7'h79 && run |=> dm_bank == $past(dm_req.wdata))
    else $error("bank write lost");
  a_top_nibble: assert property (dm_req.rd && dm_req.addr == 7'h74 |-> dm_hit && dm_rdata == pm_addr[15:12])
    else $error("top nibble wrong");
endmodule

bind sar_sysregs sar_sysregs_asserts #(.PAP_W(PAP_W), .SIDX_W(SIDX_W)) u_chk (.*);

// ===== dv/tb.sv
`timescale 1ns/10ps
module tb;
  import sar_pkg::*;
  typedef struct packed {logic [6:0] a; logic [3:0] d; logic [4:0] e;} sar_row_s;
  logic           mclk, rst, clock_stop;
  logic           wdt_stack_fault_reset, chip_enable_reset;
  sar_op_e        op;
  sar_dm_req_s    dm_req;
  sar_stack_req_s stack_req;
  sar_pc_req_s    pc_req;
  logic           dm_hit, pm_rd, data_buffer_wr, stack_index_wr;
  logic           register_file_rd, register_file_wr;
  logic [2:0]     stack_index, stack_index_d;
  logic [3:0]     dm_rdata, dm_bank, register_file_wdata, register_file_rdata;
  logic [6:0]     rf_addr, register_file_addr;
  logic [15:0]    pm_addr, pm_rdata, data_buffer_rdata, data_buffer_wdata, stack_rdata;
  int             err_total, n_checks;
  // per location: address, value written, expected {hit, read data}
  localparam sar_row_s ROWS[7] = '{'{7'h74, 4'h2, 5'h12}, '{7'h75, 4'hb, 5'h1b},
    '{7'h76, 4'hc, 5'h1c}, '{7'h77, 4'hd, 5'h1d}, '{7'h78, 4'h5, 5'h15},
    '{7'h79, 4'h9, 5'h19}, '{7'h7a, 4'h3, 5'h00}};

  sar_sysregs u_dut (.*);
  sar_core_model u_mdl (.*);

  // ----------------------------------------
  // drivers and compares
  // ----------------------------------------
  task automatic drv(sar_op_e o, logic w, logic [6:0] a, logic [3:0] d);
    @(posedge mclk);
    op <= o;
    dm_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge mclk);
  endtask
  task automatic chk(logic [23:0] g, logic [23:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #20000;
    err_total++;
    wrap_up();
  end

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    clock_stop = 1'b0;
    wdt_stack_fault_reset = 1'b0;
    chip_enable_reset = 1'b0;
    op = SAR_OP_NONE;
    dm_req = '0;
    rf_addr = 7'h12;
    data_buffer_rdata = 16'h1357;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk({pm_addr, dm_bank}, 24'h0);
    foreach (ROWS[i]) begin
      drv(SAR_OP_NONE, 1'b1, ROWS[i].a, ROWS[i].d);
      drv(SAR_OP_NONE, 1'b0, ROWS[i].a, 4'h0);
      chk({dm_hit, dm_rdata}, ROWS[i].e);
    end
    chk({pm_addr, dm_bank}, 24'h2bcd9);
    @(posedge mclk) clock_stop <= 1'b1;
    drv(SAR_OP_TABLE_RD, 1'b0, 7'h7f, 4'h0);
    chk({pm_rd, data_buffer_wdata}, 24'h1d432);
    drv(SAR_OP_IND_JUMP, 1'b0, 7'h7f, 4'h0);
    chk(pc_req, 24'h22bcd);
    drv(SAR_OP_IND_CALL, 1'b0, 7'h7f, 4'h0);
    chk(pc_req, 24'h12bcd);
    drv(SAR_OP_SAVE, 1'b0, 7'h7f, 4'h0);
    chk(stack_req, 24'hf2bcd);
    chk(pm_addr, 24'h2bcd);
    for (int i = 0; i < 4; i++) drv(SAR_OP_NONE, 1'b1, 7'h74 + 7'(i), 4'hf);
    drv(SAR_OP_STEP, 1'b0, 7'h7f, 4'h0);
    drv(SAR_OP_RESTORE, 1'b0, 7'h7f, 4'h0);
    chk(pm_addr, 24'h0);
    drv(SAR_OP_DBF_STORE, 1'b0, 7'h7f, 4'h0);
    chk({stack_index, pm_addr}, 24'h02bcd);
    drv(SAR_OP_DBF_LOAD, 1'b0, 7'h7f, 4'h0);
    drv(SAR_OP_DBF_STORE, 1'b0, 7'h7f, 4'h0);
    chk(data_buffer_wdata, 24'h1357);
    drv(SAR_OP_RF_WRITE, 1'b0, 7'h78, 4'h0);
    chk({register_file_wr, register_file_wdata}, 24'h15);
    drv(SAR_OP_NONE, 1'b1, 7'h78, 4'ha);
    drv(SAR_OP_RF_READ, 1'b0, 7'h7f, 4'h0);
    drv(SAR_OP_NONE, 1'b0, 7'h78, 4'h0);
    chk(dm_rdata, 24'h5);
    // window must survive both sync resets
    for (int k = 0; k < 2; k++) begin
      drv(SAR_OP_NONE, 1'b1, 7'h79, 4'h6);
      @(posedge mclk);
      wdt_stack_fault_reset <= (k == 0);
      chip_enable_reset <= (k == 1);
      dm_req <= '0;
      @(posedge mclk);
      wdt_stack_fault_reset <= 1'b0;
      chip_enable_reset <= 1'b0;
      drv(SAR_OP_NONE, 1'b0, 7'h78, 4'h0);
      chk({pm_addr, dm_bank, dm_rdata}, 24'h5);
    end
    wrap_up();
  end
endmodule

// ===== hw/sar_nibble_reg.sv
`timescale 1ns/10ps
`include "sar_defs.svh"

// one 4-bit system register cell with reset choice and load
module sar_nibble_reg #(
  parameter logic [3:0] RST_VAL = 4'h0,
  parameter bit         HAS_RST = 1'b1
) (
  // clock and resets
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       sys_clr,
  // load
  input  wire logic       ld,
  input  wire logic [3:0] ld_val,
  // value
  output logic [3:0]      val_q
);

  logic [3:0] val_d;

  // synchronous clears win over loads
  assign val_d = (HAS_RST && sys_clr) ? RST_VAL : (ld ? ld_val : val_q);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      val_q <= RST_VAL;
    end else begin
      val_q <= val_d;
    end
  end

endmodule

// ===== hw/sar_sysregs.sv
`timescale 1ns/10ps
`include "sar_defs.svh"

module sar_sysregs
  import sar_pkg::*;
#(
  parameter int PAP_W = 16,
  parameter int SIDX_W = 3
) (
  // clock and resets
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 wdt_stack_fault_reset,
  input  wire logic                 chip_enable_reset,
  // clock stop has no effect on state here
  input  wire logic                 clock_stop,
  // instruction from decoder
  input  wire sar_op_e              op,
  input  wire logic [6:0]           rf_addr,
  // data memory access
  input  wire sar_dm_req_s          dm_req,
  output logic [3:0]                dm_rdata,
  output logic                      dm_hit,
  output logic [3:0]                dm_bank,
  // program memory table read
  output logic [PAP_W-1:0]          pm_addr,
  output logic                      pm_rd,
  input  wire logic [15:0]          pm_rdata,
  // data buffer
  input  wire logic [15:0]          data_buffer_rdata,
  output logic [15:0]               data_buffer_wdata,
  output logic                      data_buffer_wr,
  // stack
  input  wire logic [SIDX_W-1:0]    stack_index,
  output logic [SIDX_W-1:0]         stack_index_d,
  output logic                      stack_index_wr,
  output sar_stack_req_s            stack_req,
  input  wire logic [15:0]          stack_rdata,
  // program counter
  output sar_pc_req_s               pc_req,
  // register file
  output logic [6:0]                register_file_addr,
  output logic                      register_file_rd,
  output logic                      register_file_wr,
  output logic [3:0]                register_file_wdata,
  input  wire logic [3:0]           register_file_rdata
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic        sys_clr;
  logic [15:0] pap;
  logic [15:0] pap_next;
  logic        pap_ld;
  logic [3:0]  window_q;
  logic        window_ld;
  logic [3:0]  window_val;
  logic [3:0]  bank_q;
  logic        bank_ld;
  logic [3:0]  nib_ld;
  logic        dm_wr_pap;
  logic [15:0] pap_step;
  logic [SIDX_W-1:0] sidx_dec;

  assign sys_clr = wdt_stack_fault_reset | chip_enable_reset;

  assign dm_hit = (dm_req.rd | dm_req.wr) &&
                  (dm_req.addr >= `SAR_ADDR_PAP3) && (dm_req.addr <= `SAR_ADDR_BANK);

  // bank value drives bank select straight
  assign dm_bank = bank_q;

  // carry out of bit 15 dropped, wraps to zero
  assign pap_step = pap + 16'h0001;

  assign sidx_dec = stack_index - SIDX_W'(1);

  assign pap_next = (op == SAR_OP_STEP)      ? pap_step :
                    (op == SAR_OP_RESTORE)   ? stack_rdata :
                    data_buffer_rdata;
  assign pap_ld   = (op == SAR_OP_STEP) || (op == SAR_OP_RESTORE) ||
                    (op == SAR_OP_DBF_LOAD);

  // data memory writes reach each nibble except during a pointer load
  assign dm_wr_pap = dm_req.wr && !pap_ld;
  assign nib_ld[3] = dm_wr_pap && (dm_req.addr == `SAR_ADDR_PAP3);
  assign nib_ld[2] = dm_wr_pap && (dm_req.addr == `SAR_ADDR_PAP2);
  assign nib_ld[1] = dm_wr_pap && (dm_req.addr == `SAR_ADDR_PAP1);
  assign nib_ld[0] = dm_wr_pap && (dm_req.addr == `SAR_ADDR_PAP0);

  // ----------------------------------------------------------------
  // pointer nibbles
  // ----------------------------------------------------------------
  // msb nibble at lowest location
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_nib
      sar_nibble_reg #(
        .RST_VAL (4'h0),
        .HAS_RST (1'b1)
      ) u_nib (
        .mclk    (mclk),
        .rst     (rst),
        .sys_clr (sys_clr),
        .ld      (pap_ld | nib_ld[gi]),
        .ld_val  (pap_ld ? pap_next[gi*4 +: 4] : dm_req.wdata),
        .val_q   (pap[gi*4 +: 4])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // window and bank
  // ----------------------------------------------------------------
  // register-file read fills window
  assign window_ld  = (op == SAR_OP_RF_READ) ||
                      (dm_req.wr && dm_req.addr == `SAR_ADDR_WINDOW);
  assign window_val = (op == SAR_OP_RF_READ) ? register_file_rdata : dm_req.wdata;

  // window kept through system resets; power-on value SAR_WINDOW_POR (0)
  sar_nibble_reg #(
    .RST_VAL (`SAR_WINDOW_POR),
    .HAS_RST (1'b0)
  ) u_window (
    .mclk    (mclk),
    .rst     (rst),
    .sys_clr (sys_clr),
    .ld      (window_ld),
    .ld_val  (window_val),
    .val_q   (window_q)
  );

  assign bank_ld = dm_req.wr && (dm_req.addr == `SAR_ADDR_BANK);

  // cleared by all resets, kept on stop
  sar_nibble_reg #(
    .RST_VAL (`SAR_BANK_RST),
    .HAS_RST (1'b1)
  ) u_bank (
    .mclk    (mclk),
    .rst     (rst),
    .sys_clr (sys_clr),
    .ld      (bank_ld),
    .ld_val  (dm_req.wdata),
    .val_q   (bank_q)
  );

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  logic [3:0] rd_mux;

  assign rd_mux = (dm_req.addr == `SAR_ADDR_PAP3)   ? pap[15:12] :
                  (dm_req.addr == `SAR_ADDR_PAP2)   ? pap[11:8]  :
                  (dm_req.addr == `SAR_ADDR_PAP1)   ? pap[7:4]   :
                  (dm_req.addr == `SAR_ADDR_PAP0)   ? pap[3:0]   :
                  (dm_req.addr == `SAR_ADDR_WINDOW) ? window_q   :
                  (dm_req.addr == `SAR_ADDR_BANK)   ? bank_q     : 4'h0;
  assign dm_rdata = dm_hit ? rd_mux : 4'h0;

  // ----------------------------------------------------------------
  // outward requests
  // ----------------------------------------------------------------
  // table read from pointer into data buffer
  assign pm_addr = pap;
  assign pm_rd   = (op == SAR_OP_TABLE_RD);

  // data buffer gets table word or pointer
  assign data_buffer_wr    = (op == SAR_OP_TABLE_RD) || (op == SAR_OP_DBF_STORE);
  assign data_buffer_wdata = (op == SAR_OP_TABLE_RD) ? pm_rdata : pap;

  // decrement index, write at new index
  assign stack_index_wr = (op == SAR_OP_SAVE) || (op == SAR_OP_RESTORE);
  assign stack_index_d  = (op == SAR_OP_SAVE) ? sidx_dec : stack_index + SIDX_W'(1);
  assign stack_req.wr    = (op == SAR_OP_SAVE);
  assign stack_req.idx   = sidx_dec;
  assign stack_req.wdata = pap;

  assign pc_req.jump   = (op == SAR_OP_IND_JUMP);
  assign pc_req.call   = (op == SAR_OP_IND_CALL);
  assign pc_req.target = pap;

  assign register_file_addr  = rf_addr;
  assign register_file_rd    = (op == SAR_OP_RF_READ);
  assign register_file_wr    = (op == SAR_OP_RF_WRITE);
  assign register_file_wdata = window_q;

endmodule

// ===== inc/sar_defs.svh
`ifndef SAR_DEFS_SVH
`define SAR_DEFS_SVH

// system register locations, identical in every bank
`define SAR_ADDR_PAP3     7'h74
`define SAR_ADDR_PAP2     7'h75
`define SAR_ADDR_PAP1     7'h76
`define SAR_ADDR_PAP0     7'h77
`define SAR_ADDR_WINDOW   7'h78
`define SAR_ADDR_BANK     7'h79

// reset values
`define SAR_PAP_RST       16'h0000
`define SAR_BANK_RST      4'h0
`define SAR_WINDOW_POR    4'h0

// widths
`define SAR_NIB_W         4
`define SAR_PAP_W         16
`define SAR_ADDR_W        7
`define SAR_STACK_IDX_W   3

`endif

// ===== inc/sar_pkg.sv
package sar_pkg;

  // one-hot-free instruction code seen by this block
  typedef enum logic [3:0] {
    SAR_OP_NONE      = 4'h0,
    SAR_OP_TABLE_RD  = 4'h1,
    SAR_OP_SAVE      = 4'h2,
    SAR_OP_RESTORE   = 4'h3,
    SAR_OP_IND_JUMP  = 4'h4,
    SAR_OP_IND_CALL  = 4'h5,
    SAR_OP_STEP      = 4'h6,
    SAR_OP_RF_READ   = 4'h7,
    SAR_OP_RF_WRITE  = 4'h8,
    SAR_OP_DBF_LOAD  = 4'h9,
    SAR_OP_DBF_STORE = 4'ha
  } sar_op_e;

  // data memory access from the decoder
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [3:0] wdata;
  } sar_dm_req_s;

  // stack port toward the address stack
  typedef struct packed {
    logic        wr;
    logic [2:0]  idx;
    logic [15:0] wdata;
  } sar_stack_req_s;

  // program counter load request
  typedef struct packed {
    logic        jump;
    logic        call;
    logic [15:0] target;
  } sar_pc_req_s;

endpackage
